// >>> rtl/pst_consts.vh
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH

// command codes of the status and telemetry registers
`define PST_CMD_SUMMARY_WORD    8'h79
`define PST_CMD_VOUT_STATUS     8'h7A
`define PST_CMD_INPUT_STATUS    8'h7C
`define PST_CMD_TEMP_STATUS     8'h7D
`define PST_CMD_COMM_STATUS     8'h7E
`define PST_CMD_VENDOR_STATUS   8'h80
`define PST_CMD_VIN_READING     8'h88

// summary word bit positions
`define PST_W_VOUT              15
`define PST_W_INPUT             13
`define PST_W_VENDOR            12
`define PST_W_PGOOD             11
`define PST_W_OFF               6
`define PST_W_IN_LOW_FAULT      3
`define PST_W_TEMP              2
`define PST_W_COMM              1
`define PST_W_OTHER             0

// detail byte bit positions
`define PST_VOUT_LOW_WARN       5
`define PST_IN_OV_FAULT         7
`define PST_IN_OV_WARN          6
`define PST_IN_UV_WARN          5
`define PST_IN_UV_FAULT         4
`define PST_IN_OC_FAULT         2
`define PST_IN_OC_WARN          1
`define PST_IN_OP_WARN          0
`define PST_TEMP_OT_FAULT       7
`define PST_TEMP_OT_WARN        6
`define PST_COMM_BAD_CMD        7
`define PST_COMM_BAD_DATA       6
`define PST_COMM_PEC            5
`define PST_COMM_MISC           1
`define PST_VEN_BREAKER         7
`define PST_VEN_SHORTED         6
`define PST_VEN_DEFAULTS        4

// sticky flag bank indices
`define PST_NFLAGS              21
`define PST_F_VOUT_LOW_WARN     0
`define PST_F_IN_OV_FAULT       1
`define PST_F_IN_OV_WARN        2
`define PST_F_IN_UV_WARN        3
`define PST_F_IN_UV_FAULT       4
`define PST_F_IN_OC_FAULT       5
`define PST_F_IN_OC_WARN        6
`define PST_F_IN_OP_WARN        7
`define PST_F_OT_FAULT          8
`define PST_F_OT_WARN           9
`define PST_F_BAD_CMD           10
`define PST_F_BAD_DATA          11
`define PST_F_PEC               12
`define PST_F_MISC              13
`define PST_F_BREAKER           14
`define PST_F_SHORTED           15
`define PST_F_DEFAULTS          16
`define PST_F_PGOOD_LOST        17
`define PST_F_OFF               18
`define PST_F_WORD_IN_LOW       19
`define PST_F_OTHER             20

// reset values: uv warn, defaults loaded, pgood lost, off, word uv fault, other
`define PST_FLAGS_RESET         21'h1F0008
`define PST_VIN_RESET           12'h000
`define PST_OV_DISABLED         12'hFFF
`define PST_UV_DISABLED         12'h000

`endif

// >>> rtl/pst_flag_bank.v
`timescale 1ns/1ns
`include "pst_consts.vh"

// sticky flags: a present cause sets, clear only drops flags whose cause is gone
module pst_flag_bank (
    input  wire                    clk_i,
    input  wire                    resetn_i,
    input  wire [`PST_NFLAGS-1:0]  cause_i,
    input  wire                    clear_i,
    input  wire [`PST_NFLAGS-1:0]  drop_i,
    output reg  [`PST_NFLAGS-1:0]  flags_o
);

    wire [`PST_NFLAGS-1:0] flags_next;

    // cause wins over any clear in the same cycle
    assign flags_next = cause_i | (flags_o & ~({`PST_NFLAGS{clear_i}} | drop_i));

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            flags_o <= `PST_FLAGS_RESET;
        end else begin
            flags_o <= flags_next;
        end
    end

endmodule // pst_flag_bank

// >>> rtl/pst_vin_meas.v
`timescale 1ns/1ns
`include "pst_consts.vh"

// holds the latest input voltage sample and checks it against warn limits
module pst_vin_meas (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire        sample_valid_i,
    input  wire [11:0] sample_i,
    input  wire [11:0] ov_limit_i,
    input  wire [11:0] uv_limit_i,
    output reg  [11:0] vin_o,
    output reg         ov_warn_o,
    output reg         uv_warn_o
);

    // compare the stored value, so warnings follow the telemetry value one cycle later
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            vin_o     <= `PST_VIN_RESET;
            ov_warn_o <= 1'b0;
            uv_warn_o <= 1'b0;
        end else begin
            if (sample_valid_i) begin
                vin_o <= sample_i;
            end
            ov_warn_o <= (ov_limit_i != `PST_OV_DISABLED) && (vin_o > ov_limit_i);
            uv_warn_o <= (uv_limit_i != `PST_UV_DISABLED) && (vin_o < uv_limit_i);
        end
    end

endmodule // pst_vin_meas

// >>> rtl/pst_status_regs.v
`timescale 1ns/1ns
`include "pst_consts.vh"

module pst_status_regs (
    input  wire        clk_i,
    input  wire        resetn_i,
    // command read port from the bus engine
    input  wire        rd_req_i,
    input  wire [7:0]  rd_cmd_i,
    output reg         rd_valid_o,
    output reg  [15:0] rd_data_o,
    output reg         rd_unsup_o,
    input  wire        clear_faults_i,
    // protection causes, levels
    input  wire        vout_low_i,
    input  wire        vin_ov_fault_i,
    input  wire        input_low_fault_flag_i,
    input  wire        input_overcurrent_fault_flag_i,
    input  wire        iin_oc_warn_i,
    input  wire        input_overpower_warning_flag_i,
    input  wire        ot_fault_i,
    input  wire        ot_warn_i,
    input  wire        breaker_fault_i,
    input  wire        switch_shorted_i,
    input  wire        power_good_i,
    input  wire        switch_on_i,
    input  wire        other_fault_i,
    input  wire        above_lockout_i,
    // communication events, pulses
    input  wire        bad_cmd_i,
    input  wire        bad_data_i,
    input  wire        pec_fail_i,
    input  wire        misc_comm_i,
    // input voltage telemetry and limits
    input  wire        vin_valid_i,
    input  wire [11:0] vin_sample_i,
    input  wire [11:0] vin_ov_limit_i,
    input  wire [11:0] vin_uv_limit_i,
    output reg         alert_output_n_o
);

    reg                    boot_reg;
    reg                    boot_next;
    reg  [`PST_NFLAGS-1:0] cause;
    reg  [`PST_NFLAGS-1:0] drop;
    reg  [7:0]             vout_byte;
    reg  [7:0]             input_byte;
    reg  [7:0]             temp_byte;
    reg  [7:0]             comm_byte;
    reg  [7:0]             vendor_byte;
    reg  [15:0]            word_val;
    reg  [15:0]            rd_data_next;
    reg                    unsup;
    reg                    alert_n_next;
    wire [`PST_NFLAGS-1:0] flags;
    wire [11:0]            vin_value;
    wire                   vin_ov_warn;
    wire                   vin_uv_warn;
    wire                   new_set;

    // true for every command code this bank answers
    function is_mapped;
        input [7:0] cmd;
        begin
            is_mapped = (cmd == `PST_CMD_SUMMARY_WORD) || (cmd == `PST_CMD_VOUT_STATUS) ||
                        (cmd == `PST_CMD_INPUT_STATUS) || (cmd == `PST_CMD_TEMP_STATUS) ||
                        (cmd == `PST_CMD_COMM_STATUS) || (cmd == `PST_CMD_VENDOR_STATUS) ||
                        (cmd == `PST_CMD_VIN_READING);
        end
    endfunction

    pst_vin_meas u_vin (
        .clk_i          (clk_i),
        .resetn_i       (resetn_i),
        .sample_valid_i (vin_valid_i),
        .sample_i       (vin_sample_i),
        .ov_limit_i     (vin_ov_limit_i),
        .uv_limit_i     (vin_uv_limit_i),
        .vin_o          (vin_value),
        .ov_warn_o      (vin_ov_warn),
        .uv_warn_o      (vin_uv_warn)
    );

    // causes per flag; comm events are pulses so they clear on clear-faults alone
    always @* begin
        cause = {`PST_NFLAGS{1'b0}};
        cause[`PST_F_VOUT_LOW_WARN] = vout_low_i;
        cause[`PST_F_IN_OV_FAULT]   = vin_ov_fault_i;
        cause[`PST_F_IN_OV_WARN]    = vin_ov_warn;
        cause[`PST_F_IN_UV_WARN]    = vin_uv_warn;
        cause[`PST_F_IN_UV_FAULT]   = input_low_fault_flag_i;
        cause[`PST_F_IN_OC_FAULT]   = input_overcurrent_fault_flag_i;
        cause[`PST_F_IN_OC_WARN]    = iin_oc_warn_i;
        cause[`PST_F_IN_OP_WARN]    = input_overpower_warning_flag_i;
        cause[`PST_F_OT_FAULT]      = ot_fault_i;
        cause[`PST_F_OT_WARN]       = ot_warn_i;
        cause[`PST_F_BAD_CMD]       = bad_cmd_i | (rd_req_i & ~is_mapped(rd_cmd_i));
        cause[`PST_F_BAD_DATA]      = bad_data_i;
        cause[`PST_F_PEC]           = pec_fail_i;
        cause[`PST_F_MISC]          = misc_comm_i;
        cause[`PST_F_BREAKER]       = breaker_fault_i;
        cause[`PST_F_SHORTED]       = switch_shorted_i;
        cause[`PST_F_PGOOD_LOST]    = ~power_good_i;
        cause[`PST_F_OFF]           = ~switch_on_i;
        cause[`PST_F_WORD_IN_LOW]   = input_low_fault_flag_i;
        cause[`PST_F_OTHER]         = other_fault_i;
    end

    // the startup uv warn and word input-low flags drop once, the first time input passes the lockout level
    always @* begin
        boot_next = boot_reg & ~above_lockout_i;
        drop      = {`PST_NFLAGS{1'b0}};
        drop[`PST_F_IN_UV_WARN]   = boot_reg & above_lockout_i;
        drop[`PST_F_WORD_IN_LOW]  = boot_reg & above_lockout_i;
    end

    pst_flag_bank u_flags (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cause_i  (cause),
        .clear_i  (clear_faults_i),
        .drop_i   (drop),
        .flags_o  (flags)
    );

    // detail bytes; unimplemented bits stay zero
    always @* begin
        vout_byte   = 8'h00;
        input_byte  = 8'h00;
        temp_byte   = 8'h00;
        comm_byte   = 8'h00;
        vendor_byte = 8'h00;
        vout_byte[`PST_VOUT_LOW_WARN]  = flags[`PST_F_VOUT_LOW_WARN];
        input_byte[`PST_IN_OV_FAULT]   = flags[`PST_F_IN_OV_FAULT];
        input_byte[`PST_IN_OV_WARN]    = flags[`PST_F_IN_OV_WARN];
        input_byte[`PST_IN_UV_WARN]    = flags[`PST_F_IN_UV_WARN];
        input_byte[`PST_IN_UV_FAULT]   = flags[`PST_F_IN_UV_FAULT];
        input_byte[`PST_IN_OC_FAULT]   = flags[`PST_F_IN_OC_FAULT];
        input_byte[`PST_IN_OC_WARN]    = flags[`PST_F_IN_OC_WARN];
        input_byte[`PST_IN_OP_WARN]    = flags[`PST_F_IN_OP_WARN];
        temp_byte[`PST_TEMP_OT_FAULT]  = flags[`PST_F_OT_FAULT];
        temp_byte[`PST_TEMP_OT_WARN]   = flags[`PST_F_OT_WARN];
        comm_byte[`PST_COMM_BAD_CMD]   = flags[`PST_F_BAD_CMD];
        comm_byte[`PST_COMM_BAD_DATA]  = flags[`PST_F_BAD_DATA];
        comm_byte[`PST_COMM_PEC]       = flags[`PST_F_PEC];
        comm_byte[`PST_COMM_MISC]      = flags[`PST_F_MISC];
        vendor_byte[`PST_VEN_BREAKER]  = flags[`PST_F_BREAKER];
        vendor_byte[`PST_VEN_SHORTED]  = flags[`PST_F_SHORTED];
        vendor_byte[`PST_VEN_DEFAULTS] = flags[`PST_F_DEFAULTS];
    end

    // summary word as ORs of the detail bytes and the word-only flags
    always @* begin
        word_val = 16'h0000;
        word_val[`PST_W_VOUT]         = |vout_byte;
        word_val[`PST_W_INPUT]        = (|input_byte) | flags[`PST_F_WORD_IN_LOW];
        word_val[`PST_W_VENDOR]       = |vendor_byte;
        word_val[`PST_W_PGOOD]        = flags[`PST_F_PGOOD_LOST];
        word_val[`PST_W_OFF]          = flags[`PST_F_OFF];
        word_val[`PST_W_IN_LOW_FAULT] = flags[`PST_F_WORD_IN_LOW];
        word_val[`PST_W_TEMP]         = |temp_byte;
        word_val[`PST_W_COMM]         = |comm_byte;
        // anything not reported in bits 7..1
        word_val[`PST_W_OTHER]        = flags[`PST_F_OTHER] | (|vout_byte) | (|vendor_byte) |
                                        flags[`PST_F_PGOOD_LOST] | (|input_byte);
    end

    // read mux; byte registers sit in the low byte, mapped reads are side-effect free, an unmapped code sets the bad command flag
    always @* begin
        unsup = 1'b0;
        case (rd_cmd_i)
            `PST_CMD_SUMMARY_WORD:  rd_data_next = word_val;
            `PST_CMD_VOUT_STATUS:   rd_data_next = {8'h00, vout_byte};
            `PST_CMD_INPUT_STATUS:  rd_data_next = {8'h00, input_byte};
            `PST_CMD_TEMP_STATUS:   rd_data_next = {8'h00, temp_byte};
            `PST_CMD_COMM_STATUS:   rd_data_next = {8'h00, comm_byte};
            `PST_CMD_VENDOR_STATUS: rd_data_next = {8'h00, vendor_byte};
            `PST_CMD_VIN_READING:   rd_data_next = {4'h0, vin_value};
            default: begin
                rd_data_next = 16'h0000;
                unsup        = 1'b1;
            end
        endcase
    end

    // alert follows new sets; a set in the clear cycle keeps it asserted
    assign new_set = |(cause & ~flags);
    always @* begin
        alert_n_next = alert_output_n_o;
        if (clear_faults_i) begin
            alert_n_next = 1'b1;
        end
        if (new_set) begin
            alert_n_next = 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            boot_reg         <= 1'b1;
            rd_valid_o       <= 1'b0;
            rd_data_o        <= 16'h0000;
            rd_unsup_o       <= 1'b0;
            alert_output_n_o <= 1'b1;
        end else begin
            boot_reg         <= boot_next;
            rd_valid_o       <= rd_req_i;
            rd_unsup_o       <= rd_req_i & unsup;
            alert_output_n_o <= alert_n_next;
            if (rd_req_i) begin
                rd_data_o <= rd_data_next;
            end
        end
    end

endmodule // pst_status_regs

// >>> tb/pst_status_regs_assertions.sv
`timescale 1ns/1ns
module pst_status_regs_assertions (
    input wire        clk_i,
    input wire        resetn_i,
    input wire        rd_req_i,
    input wire [7:0]  rd_cmd_i,
    input wire        rd_valid_o,
    input wire [15:0] rd_data_o,
    input wire        rd_unsup_o,
    input wire        clear_faults_i,
    input wire        ot_fault_i,
    input wire        bad_cmd_i,
    input wire        vin_valid_i,
    input wire [11:0] vin_sample_i,
    input wire        alert_output_n_o
);
    reg [7:0]  cmd_q;
    reg [11:0] vin_q;
    // code of the read being answered, and the sample a read must return
    always @(posedge clk_i) begin
        if (rd_req_i) cmd_q <= rd_cmd_i;
        if (!resetn_i) vin_q <= 12'h000;
        else if (vin_valid_i) vin_q <= vin_sample_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    ans_one_a: assert property (rd_req_i |=> rd_valid_o) else $error("read not answered");
    no_extra_a: assert property (!rd_req_i |=> !rd_valid_o && $stable(rd_data_o))
        else $error("answer or data change without read");
    unsup_zero_a: assert property (rd_unsup_o |-> rd_valid_o && rd_data_o == 16'h0000)
        else $error("refused read not zero");
    word_zero_a: assert property (rd_valid_o && cmd_q == 8'h79 |-> (rd_data_o & 16'h47B0) == 16'h0000)
        else $error("unused word bit set");
    vout_zero_a: assert property (rd_valid_o && cmd_q == 8'h7A |-> (rd_data_o & 16'hFFDF) == 16'h0000)
        else $error("unused vout bit set");
    input_zero_a: assert property (rd_valid_o && cmd_q == 8'h7C |-> (rd_data_o & 16'hFF08) == 16'h0000)
        else $error("unused input bit set");
    temp_zero_a: assert property (rd_valid_o && cmd_q == 8'h7D |-> (rd_data_o & 16'hFF3F) == 16'h0000)
        else $error("unused temp bit set");
    comm_zero_a: assert property (rd_valid_o && cmd_q == 8'h7E |-> (rd_data_o & 16'hFF1D) == 16'h0000)
        else $error("unused comm bit set");
    vendor_zero_a: assert property (rd_valid_o && cmd_q == 8'h80 |-> (rd_data_o & 16'hFF2F) == 16'h0000)
        else $error("unused vendor bit set");
    vin_read_a: assert property (rd_req_i && rd_cmd_i == 8'h88 && !vin_valid_i |=> rd_data_o == {4'h0, vin_q})
        else $error("reading not latest sample");
    alert_set_a: assert property (($rose(ot_fault_i) || bad_cmd_i) && !clear_faults_i |=> !alert_output_n_o)
        else $error("alert missing");
endmodule // pst_status_regs_assertions

bind pst_status_regs pst_status_regs_assertions u_pst_status_regs_assertions (.clk_i(clk_i), .resetn_i(resetn_i),
    .rd_req_i(rd_req_i), .rd_cmd_i(rd_cmd_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .rd_unsup_o(rd_unsup_o), .clear_faults_i(clear_faults_i), .ot_fault_i(ot_fault_i), .bad_cmd_i(bad_cmd_i),
    .vin_valid_i(vin_valid_i), .vin_sample_i(vin_sample_i), .alert_output_n_o(alert_output_n_o));

// >>> tb/pst_host_model.sv
`timescale 1ns/1ns
module pst_host_model (
    input  wire        clk_i,
    input  wire        rd_valid_i,
    input  wire [15:0] rd_data_i,
    input  wire        rd_unsup_i,
    output reg         rd_req_o = 1'b0,
    output reg  [7:0]  rd_cmd_o = 8'h00,
    output reg         clear_o = 1'b0
);
    // one-cycle read request; answer taken in the cycle after
    task rd(input [7:0] cmd, output [15:0] data, output unsup);
        @(posedge clk_i);
        #1;
        rd_req_o = 1'b1;
        rd_cmd_o = cmd;
        @(posedge clk_i);
        #1;
        rd_req_o = 1'b0;
        rd_cmd_o = ~cmd; // idle code lines never repeat a stale value
        data = rd_valid_i ? rd_data_i : 16'hDEAD; // a missing answer shows as junk
        unsup = rd_unsup_i;
    endtask
    // caller removes every cause first, else flags survive
    task clr;
        @(posedge clk_i);
        #1;
        clear_o = 1'b1;
        @(posedge clk_i);
        #1;
        clear_o = 1'b0;
    endtask
endmodule // pst_host_model

// >>> tb/pst_status_regs_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module pst_status_regs_tb;
    logic        clk_i = 0, resetn_i = 0, lockout = 0, vin_v = 0, u;
    logic        pg = 1, son = 1, oth = 0;
    logic [13:0] cv = 0;
    logic [11:0] vin_s = 12'h000, ov_lim = 12'hFFF, uv_lim = 12'h000;
    logic [15:0] d;
    wire         rd_req, clear, rd_valid, rd_unsup, alert_n;
    wire [7:0]   rd_cmd;
    wire [15:0]  rd_data;
    int          fails = 0, cmp_count = 0;
    logic [7:0]  rcmd [0:6] = '{8'h79, 8'h7A, 8'h7C, 8'h7D, 8'h7E, 8'h80, 8'h88};
    logic [15:0] rexp [0:6] = '{16'h3849, 16'h0000, 16'h0020, 16'h0000, 16'h0000, 16'h0010, 16'h0000};
    // one cause per entry: register, flag value, summary bit
    logic [7:0]  tcmd [0:13] = '{8'h7A, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7D, 8'h7D, 8'h80, 8'h80,
                                 8'h7E, 8'h7E, 8'h7E, 8'h7E};
    logic [7:0]  texp [0:13] = '{8'h20, 8'h80, 8'h10, 8'h04, 8'h02, 8'h01, 8'h80, 8'h40, 8'h80, 8'h40,
                                 8'h80, 8'h40, 8'h20, 8'h02};
    int          twb [0:13] = '{15, 13, 13, 13, 13, 13, 2, 2, 12, 12, 1, 1, 1, 1};
    always #20 clk_i = ~clk_i;
    pst_status_regs u_pst_status_regs (.clk_i(clk_i), .resetn_i(resetn_i), .rd_req_i(rd_req), .rd_cmd_i(rd_cmd),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_unsup_o(rd_unsup), .clear_faults_i(clear),
        .vout_low_i(cv[0]), .vin_ov_fault_i(cv[1]), .input_low_fault_flag_i(cv[2]), .input_overcurrent_fault_flag_i(cv[3]),
        .iin_oc_warn_i(cv[4]), .input_overpower_warning_flag_i(cv[5]), .ot_fault_i(cv[6]), .ot_warn_i(cv[7]),
        .breaker_fault_i(cv[8]), .switch_shorted_i(cv[9]), .power_good_i(pg), .switch_on_i(son),
        .other_fault_i(oth), .above_lockout_i(lockout), .bad_cmd_i(cv[10]), .bad_data_i(cv[11]),
        .pec_fail_i(cv[12]), .misc_comm_i(cv[13]), .vin_valid_i(vin_v), .vin_sample_i(vin_s),
        .vin_ov_limit_i(ov_lim), .vin_uv_limit_i(uv_lim), .alert_output_n_o(alert_n));
    pst_host_model u_pst_host_model (.clk_i(clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
        .rd_unsup_i(rd_unsup), .rd_req_o(rd_req), .rd_cmd_o(rd_cmd), .clear_o(clear));
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task t_reset;
        for (int i = 0; i < 7; i++) begin
            u_pst_host_model.rd(rcmd[i], d, u);
            `CHK(d, rexp[i])
        end
        u_pst_host_model.rd(8'h55, d, u);
        `CHK({u, d}, {1'b1, 16'h0000})
        `CHK(alert_n, 1'b0)
        u_pst_host_model.rd(8'h7E, d, u);
        `CHK(d, 16'h0080)
        u_pst_host_model.clr;
        u_pst_host_model.rd(8'h7E, d, u);
        `CHK(d, 16'h0000)
        $display("test reset done");
    endtask
    task t_lockout;
        lockout = 1'b1;
        step(2);
        u_pst_host_model.rd(8'h79, d, u);
        `CHK(d & 16'h2008, 16'h0000)
        u_pst_host_model.rd(8'h7C, d, u);
        `CHK(d, 16'h0000)
        u_pst_host_model.clr;
        u_pst_host_model.rd(8'h79, d, u);
        `CHK(d & 16'h0840, 16'h0000)
        $display("test lockout done");
    endtask
    // each of the 14 cause-input flags: set by a one-cycle cause, seen in detail and summary, then cleared
    task t_table;
        for (int i = 0; i < 14; i++) begin
            cv = 14'h0001 << i;
            step(1);
            cv = 14'h0000;
            `CHK(alert_n, 1'b0)
            u_pst_host_model.rd(tcmd[i], d, u);
            `CHK(d[7:0] & (tcmd[i] == 8'h80 ? 8'hEF : 8'hFF), texp[i])
            u_pst_host_model.rd(8'h79, d, u);
            `CHK(d[twb[i]], 1'b1)
            u_pst_host_model.clr;
            `CHK(alert_n, 1'b1)
            u_pst_host_model.rd(tcmd[i], d, u);
            `CHK(d[7:0] & (tcmd[i] == 8'h80 ? 8'hEF : 8'hFF), 8'h00)
        end
        $display("test table done");
    endtask
    task t_sticky;
        cv[6] = 1'b1;
        step(1);
        u_pst_host_model.clr;
        u_pst_host_model.rd(8'h7D, d, u);
        `CHK(d, 16'h0080)
        cv[6] = 1'b0;
        u_pst_host_model.clr;
        u_pst_host_model.rd(8'h7D, d, u);
        `CHK(d, 16'h0000)
        $display("test sticky done");
    endtask
    // three edges from sample to warning flag, so four cycles are waited
    task t_vin;
        vin_s = 12'hABC;
        vin_v = 1'b1;
        step(1);
        vin_v = 1'b0;
        u_pst_host_model.rd(8'h88, d, u);
        `CHK(d, 16'h0ABC)
        ov_lim = 12'h800;
        step(4);
        u_pst_host_model.rd(8'h7C, d, u);
        `CHK(d, 16'h0040)
        ov_lim = 12'hFFF;
        uv_lim = 12'hB00;
        step(4);
        u_pst_host_model.clr;
        u_pst_host_model.rd(8'h7C, d, u);
        `CHK(d, 16'h0020)
        uv_lim = 12'h000;
        step(4);
        u_pst_host_model.clr;
        u_pst_host_model.rd(8'h7C, d, u);
        `CHK(d, 16'h0000)
        $display("test vin done");
    endtask
    // power-good loss, switch off and other fault reach the summary word
    task t_power;
        pg = 1'b0;
        son = 1'b0;
        oth = 1'b1;
        step(1);
        pg = 1'b1;
        son = 1'b1;
        oth = 1'b0;
        `CHK(alert_n, 1'b0)
        u_pst_host_model.rd(8'h79, d, u);
        `CHK(d, 16'h0841)
        u_pst_host_model.clr;
        u_pst_host_model.rd(8'h79, d, u);
        `CHK(d, 16'h0000)
        $display("test power done");
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        step(8);
        resetn_i = 1'b1;
        t_reset;
        t_lockout;
        t_table;
        t_sticky;
        t_vin;
        t_power;
        end_sim;
    end
    // whole run is well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        end_sim;
    end
endmodule // pst_status_regs_tb
